// ==== common/asc_pkg.sv ====
// Constants for the converter scan and threshold compare controller.
// Assumes one system clock and a plain address/strobe register port.
package asc_pkg;

  // Register port widths
  localparam int unsigned ADDR_W = 4;   // Register index width
  localparam int unsigned REG_W  = 16;  // Register data width

  // Register indexes on the plain port
  localparam logic [3:0] CTRL_ADDR = 4'h0;  // Scan and compare control
  localparam logic [3:0] STAT_ADDR = 4'h1;  // Sticky event status
  localparam logic [3:0] MASK_ADDR = 4'h2;  // Interrupt mask

  // Control field positions
  localparam int unsigned SCAN_EN_BIT   = 15;  // Auto-scan enable
  localparam int unsigned LOW_PWR_BIT   = 14;  // Low power after scan
  localparam int unsigned CHG_REQ_BIT   = 13;  // Charge time unit request
  localparam int unsigned BGAP_REQ_BIT  = 12;  // Band gap request
  localparam int unsigned SIRQ_MODE_LSB = 8;   // Scan interrupt mode
  localparam int unsigned WR_MODE_LSB   = 2;   // Result write mode
  localparam int unsigned CMP_MODE_LSB  = 0;   // Compare mode

  // Control reset value and writable bits
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'hf30f;

  // Scan interrupt modes
  localparam logic [1:0] SIRQ_NONE = 2'h0;  // No interrupt
  localparam logic [1:0] SIRQ_SEQ  = 2'h1;  // Sequence complete
  localparam logic [1:0] SIRQ_CMP  = 2'h2;  // Valid compare
  localparam logic [1:0] SIRQ_BOTH = 2'h3;  // Sequence and compare

  // Result write modes
  localparam logic [1:0] WR_LEGACY = 2'h0;  // Store every result
  localparam logic [1:0] WR_MATCH  = 2'h1;  // Store on match only
  localparam logic [1:0] WR_CMPONL = 2'h2;  // Compare only, no store
  localparam logic [1:0] WR_RSVD   = 2'h3;  // Reserved

  // Compare modes
  localparam logic [1:0] CMP_LT  = 2'h0;  // Below buffer value
  localparam logic [1:0] CMP_GT  = 2'h1;  // Above buffer value
  localparam logic [1:0] CMP_IN  = 2'h2;  // Inside window
  localparam logic [1:0] CMP_OUT = 2'h3;  // Outside window

  // Status bits, also the mask layout
  localparam int unsigned ST_W    = 3;  // Status width
  localparam int unsigned ST_SIRQ = 0;  // Scan interrupt condition met
  localparam int unsigned ST_MTCH = 1;  // Valid compare seen
  localparam int unsigned ST_SEQ  = 2;  // Sequence completed
  localparam logic [2:0]  STAT_RST = 3'h0;
  localparam logic [2:0]  MASK_RST = 3'h0;

  // Two-bit field extract, used for every mode field
  function automatic logic [1:0] fld2(input logic [15:0] r, input int unsigned lsb);
    fld2 = r[lsb +: 2];
  endfunction : fld2

endpackage : asc_pkg

// ==== hw/asc_cmp.sv ====
// Threshold comparator for one conversion result.
// Assumes the buffer value and window pair are stable beside the result.
`timescale 1ns/1ps
`default_nettype none
module asc_cmp #(
  parameter int unsigned RES_W = 12  // Result width
) (
  // Mode select
  input  wire logic [1:0]       mode_i,
  // Values to compare
  input  wire logic [RES_W-1:0] result_i,
  input  wire logic [RES_W-1:0] lo_i,
  input  wire logic [RES_W-1:0] hi_i,
  // Outcome
  output logic                  match_o
);

  // Window edges count as inside
  logic in_win;  // Result within lo..hi

  // Criterion select
  always_comb
  begin
    in_win = (result_i >= lo_i) && (result_i <= hi_i);
    case (mode_i)
      asc_pkg::CMP_LT:  match_o = result_i < lo_i;
      asc_pkg::CMP_GT:  match_o = result_i > lo_i;
      asc_pkg::CMP_IN:  match_o = in_win;
      asc_pkg::CMP_OUT: match_o = !in_win;
      default:         match_o = 1'b0;
    endcase
  end

endmodule : asc_cmp
`default_nettype wire

// ==== hw/asc_ctrl.sv ====
// Scan and threshold compare controller for a converter core.
// Assumes the core pulses conv_done_i with result and buffer index,
// pulses seq_done_i at the end of a scan sequence, and supplies the
// buffer value (lo) and window pair (lo, hi) for each conversion.
//
// Function
// - Auto-scan bit turns automatic scanning on.
// - Charge time unit on only when requested, active.
// - Band gap on only when requested, active.
// - Interrupt mode: none, sequence, compare, both.
// - Compare-only mode stores nothing, still interrupts.
// - Legacy mode stores every result at index.
// - Compare mode: below, above, inside, outside.
// - Match-store mode acts only on a match.
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl #(
  parameter int unsigned RES_W = 12,  // Result width
  parameter int unsigned IDX_W = 5    // Buffer index width
) (
  // Clock and reset
  input  wire logic                         clk_sys_i,
  input  wire logic                         arst_n_i,
  // Register port
  input  wire logic [asc_pkg::ADDR_W-1:0]   reg_addr_i,
  input  wire logic [asc_pkg::REG_W-1:0]    reg_wdata_i,
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  output logic      [asc_pkg::REG_W-1:0]    reg_rdata_o,
  // Converter core status
  input  wire logic                         adc_on_i,
  input  wire logic                         adc_active_i,
  input  wire logic                         conv_done_i,
  input  wire logic [RES_W-1:0]             conv_result_i,
  input  wire logic [IDX_W-1:0]             conv_idx_i,
  input  wire logic [RES_W-1:0]             thr_lo_i,
  input  wire logic [RES_W-1:0]             thr_hi_i,
  input  wire logic                         seq_done_i,
  // Converter core controls
  output logic                              auto_scan_enable_o,
  output logic                              low_power_after_scan_o,
  output logic                              chg_unit_en_o,
  output logic                              bandgap_en_o,
  // Result store to buffer
  output logic                              store_o,
  output logic      [RES_W-1:0]             store_data_o,
  output logic      [IDX_W-1:0]             store_idx_o,
  // Events
  output logic                              scan_event_o,
  output logic                              irq_o
);

  // Scan tracking states
  typedef enum logic [0:0] {
    ASC_IDLE,  // No scan in progress
    ASC_RUN    // Auto-scan running
  } asc_state_e;

  // Register state
  logic [15:0]                ctrl_r;        // Control register
  logic [15:0]                ctrl_nxt;
  logic [asc_pkg::ST_W-1:0]   stat_r;        // Sticky status
  logic [asc_pkg::ST_W-1:0]   stat_nxt;
  logic [asc_pkg::ST_W-1:0]   mask_r;        // Interrupt mask
  logic [asc_pkg::ST_W-1:0]   mask_nxt;
  logic [15:0]                rdata_r;       // Read data
  logic [15:0]                rdata_nxt;

  // Scan state
  asc_state_e                 state_r;       // Scan tracker
  asc_state_e                 state_nxt;
  logic                       seen_r;        // Match seen this sequence
  logic                       seen_nxt;

  // Output registers
  logic                       scan_en_r;
  logic                       scan_en_nxt;
  logic                       lp_r;
  logic                       lp_nxt;
  logic                       chg_r;
  logic                       chg_nxt;
  logic                       bg_r;
  logic                       bg_nxt;
  logic                       store_r;
  logic                       store_nxt;
  logic [RES_W-1:0]           sdata_r;
  logic [RES_W-1:0]           sdata_nxt;
  logic [IDX_W-1:0]           sidx_r;
  logic [IDX_W-1:0]           sidx_nxt;
  logic                       sev_r;
  logic                       sev_nxt;
  logic                       irq_r;
  logic                       irq_nxt;

  // Decoded fields
  logic [1:0]                 sirq_mode;     // Scan interrupt mode
  logic [1:0]                 wr_mode;       // Result write mode
  logic [1:0]                 cmp_mode;      // Compare mode
  logic                       cmp_raw;       // Comparator outcome
  logic                       cmp_on;        // Compare is in use
  logic                       match;         // Valid match this cycle
  logic                       sirq;          // Scan interrupt condition
  logic                       rd_stat;       // Status read this cycle
  logic [asc_pkg::ST_W-1:0]   ev;            // Events this cycle

  // Field decode
  assign sirq_mode = asc_pkg::fld2(ctrl_r, asc_pkg::SIRQ_MODE_LSB);
  assign wr_mode   = asc_pkg::fld2(ctrl_r, asc_pkg::WR_MODE_LSB);
  assign cmp_mode  = asc_pkg::fld2(ctrl_r, asc_pkg::CMP_MODE_LSB);

  // Threshold comparator
  asc_cmp #(
    .RES_W    (RES_W)
  ) u_cmp (
    .mode_i   (cmp_mode),
    .result_i (conv_result_i),
    .lo_i     (thr_lo_i),
    .hi_i     (thr_hi_i),
    .match_o  (cmp_raw)
  );

  // Compare is used only in the two compare write modes
  assign cmp_on = (wr_mode == asc_pkg::WR_MATCH) || (wr_mode == asc_pkg::WR_CMPONL);
  assign match  = conv_done_i && cmp_on && cmp_raw;

  // Scan interrupt condition by mode
  always_comb
  begin
    case (sirq_mode)
      asc_pkg::SIRQ_SEQ:  sirq = seq_done_i;
      asc_pkg::SIRQ_CMP:  sirq = match;
      asc_pkg::SIRQ_BOTH: sirq = seq_done_i && (seen_r || match);
      default:             sirq = 1'b0;
    endcase
  end

  // Register file next values
  always_comb
  begin
    ctrl_nxt  = ctrl_r;
    mask_nxt  = mask_r;
    rdata_nxt = 16'h0000;
    rd_stat   = reg_rd_i && (reg_addr_i == asc_pkg::STAT_ADDR);
    ev        = '0;
    ev[asc_pkg::ST_SIRQ] = sirq;
    ev[asc_pkg::ST_MTCH] = match;
    ev[asc_pkg::ST_SEQ]  = seq_done_i;
    // Software writes
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        asc_pkg::CTRL_ADDR: ctrl_nxt = reg_wdata_i & asc_pkg::CTRL_WMASK;
        asc_pkg::MASK_ADDR: mask_nxt = reg_wdata_i[asc_pkg::ST_W-1:0];
        default:            ctrl_nxt = ctrl_r;
      endcase
    end
    // Software reads, unmapped read as zero
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        asc_pkg::CTRL_ADDR: rdata_nxt = ctrl_r;
        asc_pkg::STAT_ADDR: rdata_nxt = {13'h0000, stat_r};
        asc_pkg::MASK_ADDR: rdata_nxt = {13'h0000, mask_r};
        default:            rdata_nxt = 16'h0000;
      endcase
    end
    // Read clears, a new event in the same cycle wins
    stat_nxt = (rd_stat ? '0 : stat_r) | ev;
  end

  // Register file flops
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_r  <= asc_pkg::CTRL_RST;
      stat_r  <= asc_pkg::STAT_RST;
      mask_r  <= asc_pkg::MASK_RST;
      rdata_r <= 16'h0000;
    end
    else
    begin
      ctrl_r  <= ctrl_nxt;
      stat_r  <= stat_nxt;
      mask_r  <= mask_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Scan tracker next values
  always_comb
  begin
    state_nxt = state_r;
    seen_nxt  = seen_r;
    case (state_r)
      ASC_IDLE:
      begin
        // A fresh scan starts with no match recorded
        seen_nxt = 1'b0;
        if (ctrl_r[asc_pkg::SCAN_EN_BIT] && adc_active_i)
        begin
          state_nxt = ASC_RUN;
        end
      end
      ASC_RUN:
      begin
        // Remember a match until the sequence closes
        if (seq_done_i)
        begin
          seen_nxt = 1'b0;
        end
        else if (match)
        begin
          seen_nxt = 1'b1;
        end
        if (!ctrl_r[asc_pkg::SCAN_EN_BIT] || !adc_on_i)
        begin
          state_nxt = ASC_IDLE;
        end
      end
      default:
      begin
        state_nxt = ASC_IDLE;
        seen_nxt  = 1'b0;
      end
    endcase
  end

  // Scan tracker flops
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_r <= ASC_IDLE;
      seen_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      seen_r  <= seen_nxt;
    end
  end

  // Output next values
  always_comb
  begin
    scan_en_nxt = ctrl_r[asc_pkg::SCAN_EN_BIT];
    lp_nxt      = ctrl_r[asc_pkg::LOW_PWR_BIT];
    chg_nxt     = ctrl_r[asc_pkg::CHG_REQ_BIT] && adc_on_i && adc_active_i;
    bg_nxt      = ctrl_r[asc_pkg::BGAP_REQ_BIT] && adc_on_i && adc_active_i;
    sdata_nxt   = sdata_r;
    sidx_nxt    = sidx_r;
    // Store decision by write mode
    case (wr_mode)
      asc_pkg::WR_LEGACY: store_nxt = conv_done_i;
      asc_pkg::WR_MATCH:  store_nxt = match;
      asc_pkg::WR_CMPONL: store_nxt = 1'b0;
      default:            store_nxt = 1'b0;
    endcase
    if (store_nxt)
    begin
      sdata_nxt = conv_result_i;
      sidx_nxt  = conv_idx_i;
    end
    sev_nxt = sirq;
    // Level interrupt from unmasked sticky bits, mask writes count at once
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  // Output flops
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      scan_en_r <= 1'b0;
      lp_r      <= 1'b0;
      chg_r     <= 1'b0;
      bg_r      <= 1'b0;
      store_r   <= 1'b0;
      sdata_r   <= '0;
      sidx_r    <= '0;
      sev_r     <= 1'b0;
      irq_r     <= 1'b0;
    end
    else
    begin
      scan_en_r <= scan_en_nxt;
      lp_r      <= lp_nxt;
      chg_r     <= chg_nxt;
      bg_r      <= bg_nxt;
      store_r   <= store_nxt;
      sdata_r   <= sdata_nxt;
      sidx_r    <= sidx_nxt;
      sev_r     <= sev_nxt;
      irq_r     <= irq_nxt;
    end
  end

  // Port drive
  assign reg_rdata_o            = rdata_r;
  assign auto_scan_enable_o     = scan_en_r;
  assign low_power_after_scan_o = lp_r;
  assign chg_unit_en_o          = chg_r;
  assign bandgap_en_o           = bg_r;
  assign store_o                = store_r;
  assign store_data_o           = sdata_r;
  assign store_idx_o            = sidx_r;
  assign scan_event_o           = sev_r;
  assign irq_o                  = irq_r;

  // Checks on this block's own outputs
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  // Mode words as sampled
  sequence legacy_conv_s;
    conv_done_i && (wr_mode == asc_pkg::WR_LEGACY);
  endsequence

  sequence cmp_only_conv_s;
    conv_done_i && (wr_mode == asc_pkg::WR_CMPONL);
  endsequence

  sequence both_fire_s;
    (sirq_mode == asc_pkg::SIRQ_BOTH) && seq_done_i && (seen_r || match);
  endsequence

  scan_enable_a: assert property (
    ##1 auto_scan_enable_o == $past(ctrl_r[asc_pkg::SCAN_EN_BIT]))
    else $error("auto-scan output does not follow its control bit");

  chg_gate_a: assert property (
    chg_unit_en_o |-> $past(ctrl_r[asc_pkg::CHG_REQ_BIT]) && $past(adc_on_i) && $past(adc_active_i))
    else $error("charge time unit enabled without request or activity");

  bandgap_gate_a: assert property (
    (ctrl_r[asc_pkg::BGAP_REQ_BIT] && adc_on_i && adc_active_i) |=> bandgap_en_o)
    else $error("band gap not enabled while requested and active");

  irq_none_a: assert property (
    (sirq_mode == asc_pkg::SIRQ_NONE) |=> !scan_event_o)
    else $error("scan event raised with interrupt mode off");

  irq_both_a: assert property (
    both_fire_s |=> scan_event_o && stat_r[asc_pkg::ST_SIRQ])
    else $error("combined scan interrupt missing");

  cmp_only_a: assert property (
    cmp_only_conv_s |=> !store_o)
    else $error("result stored in compare-only mode");

  legacy_store_a: assert property (
    legacy_conv_s |=> store_o && (store_idx_o == $past(conv_idx_i)) && (store_data_o == $past(conv_result_i)))
    else $error("legacy store missing or wrong");

  cmp_below_a: assert property (
    (conv_done_i && cmp_on && (cmp_mode == asc_pkg::CMP_LT) && (conv_result_i >= thr_lo_i)) |-> !match)
    else $error("below-mode match on a result not below the buffer value");

  match_store_a: assert property (
    (conv_done_i && (wr_mode == asc_pkg::WR_MATCH)) |=> (store_o == $past(cmp_raw)))
    else $error("match-store mode stored without a match");

  reserved_mode_a: assert property (
    (wr_mode == asc_pkg::WR_RSVD) |=> !store_o && (!stat_r[asc_pkg::ST_MTCH] || $past(stat_r[asc_pkg::ST_MTCH])))
    else $error("reserved write mode produced activity");

  irq_level_a: assert property (
    ##1 irq_o == |(stat_r & mask_r))
    else $error("interrupt level disagrees with masked status");

endmodule : asc_ctrl
`default_nettype wire

// ==== bench/asc_core_model.sv ====
// Behavioural converter core with result buffers, far side of the controller.
// Assumes the bench calls its tasks; all lines change after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module asc_core_model #(
  parameter int unsigned RES_W = 12,  // Result width
  parameter int unsigned IDX_W = 5    // Buffer index width
) (
  // Clock
  input  wire logic             clk_sys_i,
  // Core status to the controller
  output logic                  adc_on_o,
  output logic                  adc_active_o,
  output logic                  conv_done_o,
  output logic [RES_W-1:0]      conv_result_o,
  output logic [IDX_W-1:0]      conv_idx_o,
  output logic [RES_W-1:0]      thr_lo_o,
  output logic [RES_W-1:0]      thr_hi_o,
  output logic                  seq_done_o,
  // Store requests from the controller
  input  wire logic             store_i,
  input  wire logic [RES_W-1:0] store_data_i,
  input  wire logic [IDX_W-1:0] store_idx_i
);
  logic [RES_W-1:0] mem_q [2**IDX_W];  // Result buffer
  initial
  begin
    adc_on_o      = 1'b0;
    adc_active_o  = 1'b0;
    conv_done_o   = 1'b0;
    conv_result_o = '0;
    conv_idx_o    = '0;
    thr_lo_o      = 12'h064;
    thr_hi_o      = 12'h0c8;
    seq_done_o    = 1'b0;
  end
  // Buffer write on each store pulse
  always @(posedge clk_sys_i)
  begin
    if (store_i)
      mem_q[store_idx_i] <= store_data_i;
  end
  // Converter enable and activity levels
  task automatic set_adc(input logic on, input logic act);
    @(posedge clk_sys_i);
    adc_on_o     <= on;
    adc_active_o <= act;
  endtask : set_adc
  // Back-to-back conversions; lines show inverted data once released
  task automatic burst(input int n, input logic [RES_W-1:0] r0, input logic [IDX_W-1:0] i0);
    for (int k = 0; k < n; k++)
    begin
      @(posedge clk_sys_i);
      conv_done_o   <= 1'b1;
      conv_result_o <= r0 + RES_W'(k);
      conv_idx_o    <= i0 + IDX_W'(k);
    end
    @(posedge clk_sys_i);
    conv_done_o   <= 1'b0;
    conv_result_o <= ~(r0 + RES_W'(n - 1));
    conv_idx_o    <= ~(i0 + IDX_W'(n - 1));
  endtask : burst
  // One sequence-complete pulse
  task automatic seq_end();
    @(posedge clk_sys_i);
    seq_done_o <= 1'b1;
    @(posedge clk_sys_i);
    seq_done_o <= 1'b0;
  endtask : seq_end
endmodule : asc_core_model
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the scan and threshold compare controller.
// Assumes the core model on the far side and a plain strobe register port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic [1:0] wmode; logic [1:0] cmode; logic [11:0] r; logic st; logic mt;} asc_row_s;
  logic        clk_sys_i = 1'b0;  // 40 MHz clock
  logic        arst_n_i  = 1'b0;  // Reset, active low
  logic [3:0]  addr = 4'h0;       // Register port
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        on, act, done, seq, store, ase, lpa, chg, bg, sev, irq;
  logic [11:0] res, lo, hi, sdata;
  logic [4:0]  idx, sidx;
  logic [15:0] v;                 // Read data
  int          num_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          stores = 0;
  asc_row_s    rows [11] = '{
    '{2'h0, 2'h0, 12'h032, 1'b1, 1'b0}, '{2'h1, 2'h0, 12'h032, 1'b1, 1'b1},
    '{2'h1, 2'h0, 12'h064, 1'b0, 1'b0}, '{2'h1, 2'h1, 12'h0c9, 1'b1, 1'b1},
    '{2'h1, 2'h1, 12'h064, 1'b0, 1'b0}, '{2'h1, 2'h2, 12'h064, 1'b1, 1'b1},
    '{2'h1, 2'h2, 12'h0c9, 1'b0, 1'b0}, '{2'h1, 2'h3, 12'h063, 1'b1, 1'b1},
    '{2'h1, 2'h3, 12'h0c8, 1'b0, 1'b0}, '{2'h2, 2'h0, 12'h032, 1'b0, 1'b1},
    '{2'h3, 2'h0, 12'h032, 1'b0, 1'b0}};
  always #12.5 clk_sys_i = ~clk_sys_i;
  asc_ctrl DUT (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .adc_on_i(on), .adc_active_i(act),
    .conv_done_i(done), .conv_result_i(res), .conv_idx_i(idx), .thr_lo_i(lo), .thr_hi_i(hi),
    .seq_done_i(seq), .auto_scan_enable_o(ase), .low_power_after_scan_o(lpa), .chg_unit_en_o(chg),
    .bandgap_en_o(bg), .store_o(store), .store_data_o(sdata), .store_idx_o(sidx),
    .scan_event_o(sev), .irq_o(irq));
  asc_core_model u_core (.clk_sys_i(clk_sys_i), .adc_on_o(on), .adc_active_o(act), .conv_done_o(done),
    .conv_result_o(res), .conv_idx_o(idx), .thr_lo_o(lo), .thr_hi_o(hi), .seq_done_o(seq),
    .store_i(store), .store_data_i(sdata), .store_idx_i(sidx));
  // Store pulse counter and hang guard
  always @(posedge clk_sys_i)
  begin
    stores <= stores + int'(store);
    cyc    <= cyc + 1;
    if (cyc == 6000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    // Ordinary compare and store cases
    foreach (rows[i])
    begin
      reg_wr(asc_pkg::CTRL_ADDR, {6'h00, asc_pkg::SIRQ_CMP, 4'h0, rows[i].wmode, rows[i].cmode});
      u_core.burst(1, rows[i].r, 5'(i));
      #1 check(16'(store), 16'(rows[i].st));
      if (rows[i].st)
        check({sdata, 4'(sidx)}, {rows[i].r, 4'(i)});
      reg_rd(asc_pkg::STAT_ADDR, v);
      check(v, {14'h0, rows[i].mt, rows[i].mt});
    end
    $display("compare rows done");
    // Control register access and field outputs
    reg_wr(asc_pkg::CTRL_ADDR, 16'hffff);
    reg_rd(asc_pkg::CTRL_ADDR, v);
    check(v, 16'hf30f);
    check({ase, lpa}, 16'h0003);
    reg_wr(asc_pkg::STAT_ADDR, 16'h0007);
    reg_rd(asc_pkg::STAT_ADDR, v);
    check(v, 16'h0000);
    reg_rd(4'h5, v);
    check(v, 16'h0000);
    // Auxiliary resource requests
    u_core.set_adc(1'b1, 1'b0);
    repeat (2) @(posedge clk_sys_i);
    #1 check({chg, bg}, 16'h0000);
    u_core.set_adc(1'b1, 1'b1);
    repeat (2) @(posedge clk_sys_i);
    #1 check({chg, bg}, 16'h0003);
    reg_wr(asc_pkg::CTRL_ADDR, 16'h9000);
    repeat (2) @(posedge clk_sys_i);
    #1 check({ase, lpa, chg, bg}, 16'h0009);
    $display("control fields done");
    // Scan interrupt modes, with and without a match
    for (int m = 0; m < 5; m++)
    begin
      reg_wr(asc_pkg::CTRL_ADDR, {6'h20, ((m == 4) ? 2'h3 : 2'(m)), 8'h04});
      u_core.burst(1, (m == 4) ? 12'h0c8 : 12'h032, 5'h1f);
      u_core.seq_end();
      #1 check(16'(sev), 16'(m == 1 || m == 3));
      reg_rd(asc_pkg::STAT_ADDR, v);
      check(v, {13'h0, 1'b1, m != 4, m == 1 || m == 2 || m == 3});
    end
    $display("interrupt modes done");
    // Interrupt output with mask
    reg_wr(asc_pkg::CTRL_ADDR, 16'h0004);
    reg_wr(asc_pkg::MASK_ADDR, 16'h0002);
    u_core.burst(1, 12'h010, 5'h02);
    #1 check(16'(irq), 16'h0001);
    reg_rd(asc_pkg::STAT_ADDR, v);
    check(v, 16'h0002);
    repeat (2) @(posedge clk_sys_i);
    #1 check(16'(irq), 16'h0000);
    reg_wr(asc_pkg::MASK_ADDR, 16'h0000);
    u_core.burst(1, 12'h010, 5'h02);
    #1 check(16'(irq), 16'h0000);
    reg_wr(asc_pkg::MASK_ADDR, 16'h0002);
    repeat (2) @(posedge clk_sys_i);
    #1 check(16'(irq), 16'h0001);
    reg_rd(asc_pkg::STAT_ADDR, v);
    check(v, 16'h0002);
    $display("interrupt mask done");
    // Back-to-back conversions in legacy mode
    reg_wr(asc_pkg::CTRL_ADDR, 16'h0000);
    @(posedge clk_sys_i);
    v = 16'(stores);
    u_core.burst(4, 12'h3f0, 5'h08);
    repeat (2) @(posedge clk_sys_i);
    check(16'(stores) - v, 16'h0004);
    for (int k = 0; k < 4; k++)
      check(16'(u_core.mem_q[8 + k]), 16'h03f0 + 16'(k));
    $display("burst done");
    // Second reset in mid-run, with every field set before it
    reg_wr(asc_pkg::CTRL_ADDR, 16'hf30f);
    reg_wr(asc_pkg::MASK_ADDR, 16'h0007);
    #1 check({ase, lpa, chg, bg}, 16'h000f);
    @(posedge clk_sys_i);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    reg_rd(asc_pkg::CTRL_ADDR, v);
    check(v, 16'h0000);
    check({ase, chg, bg, irq}, 16'h0000);
    reg_rd(asc_pkg::MASK_ADDR, v);
    check(v, 16'h0000);
    $display("reset done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
